// ---- verilog/ptc_pkg.sv ----
// Purpose: shared constants and types for the time-stamp unit control block
// Assumes: 32-bit classic Wishbone register bus, 40 MHz ref_clk
// Notes:   offsets are byte addresses, one aligned word per register
package ptc_pkg;

  // bus shape
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;

  // register offsets
  localparam logic [31:0] CMD_CTL_OFS  = 32'h0000_0100;
  localparam logic [31:0] GEN_CFG_OFS  = 32'h0000_0104;
  localparam logic [31:0] EVT_STS_OFS  = 32'h0000_0108;
  localparam logic [31:0] EVT_MASK_OFS = 32'h0000_010c;
  localparam logic [31:0] INT_STS_OFS  = 32'h0000_0110;

  // command register bits
  localparam int CMD_RESET_BIT   = 0;
  localparam int CMD_DISABLE_BIT = 1;
  localparam int CMD_ENABLE_BIT  = 2;
  localparam int CMD_LANE        = 0;

  // general configuration fields
  localparam int PORT_COUNT      = 3;
  localparam int CFG_PORT_LSB    = 16;
  localparam int CFG_CLR_EN_BIT  = 15;
  localparam int CFG_SEL_LSB     = 12;
  localparam int CFG_SEL_W       = 3;
  localparam int CFG_PORT_LANE   = 2;
  localparam int CFG_CLR_LANE    = 1;

  // interrupt status and event bits
  localparam int TIMER_B_BIT          = 1;
  localparam int EVT_W                = 2;
  localparam int EVT_DRAIN_DONE_BIT   = 0;
  localparam int EVT_GPIO_CLEAR_BIT   = 1;
  localparam int EVT_LANE             = 0;

  // pins
  localparam int GPIO_COUNT = 8;
  localparam int SYNC_W     = GPIO_COUNT + 1;
  localparam int STRAP_IDX  = GPIO_COUNT;

  // values after reset
  localparam logic [PORT_COUNT-1:0] PORT_EN_RST  = 3'h7;
  localparam logic                  CLR_EN_RST   = 1'h0;
  localparam logic [CFG_SEL_W-1:0]  CLR_SEL_RST  = 3'h0;
  localparam logic [EVT_W-1:0]      EVT_MASK_RST = 2'h0;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned CLR_ACTIVE_NS  = 40;
  localparam int unsigned CLR_MIN_CYC_I  = (CLR_ACTIVE_NS / CLK_PERIOD_NS < 1) ? 1 : CLR_ACTIVE_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  CLR_MIN_CYC    = 2'(CLR_MIN_CYC_I);
  localparam logic [2:0]  STRAP_SETTLE_CYC = 3'h4;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [3:0]        sel;
    logic [DATA_W-1:0] dat;
  } ptc_wb_req_type;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } ptc_wb_rsp_type;

  typedef struct packed {
    logic [PORT_COUNT-1:0] portEn;
    logic                  clrEn;
    logic [CFG_SEL_W-1:0]  clrSel;
  } ptc_gen_cfg_type;

  typedef enum logic [1:0] {RUN_OFF, RUN_ON, RUN_DRAIN} ptc_run_type;

endpackage : ptc_pkg

// ---- verilog/ptc_pin_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to ref_clk
// Notes:   output level moves only when the second and third stages agree
`timescale 1ns/10ps
`default_nettype none
module ptc_pin_sync (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // pins
  input  wire logic [ptc_pkg::SYNC_W-1:0] pinIn,
  output var  logic [ptc_pkg::SYNC_W-1:0] pinStable
);
  import ptc_pkg::*;

  logic [SYNC_W-1:0] stage1_r;
  logic [SYNC_W-1:0] stage2_r;
  logic [SYNC_W-1:0] stage3_r;

  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          stage1_r[i]  <= 1'b0;
          stage2_r[i]  <= 1'b0;
          stage3_r[i]  <= 1'b0;
          pinStable[i] <= 1'b0;
        end else begin
          stage1_r[i] <= pinIn[i];
          stage2_r[i] <= stage1_r[i];
          stage3_r[i] <= stage2_r[i];
          if (stage2_r[i] == stage3_r[i]) begin
            pinStable[i] <= stage3_r[i];
          end
        end
      end
    end
  endgenerate

  chk_sync_agree_move: assert property (@(posedge ref_clk) disable iff (reset)
    (pinStable != $past(pinStable)) |-> ($past(stage2_r) == $past(stage3_r)))
    else $error("stable level moved without stage agreement");

endmodule : ptc_pin_sync
`default_nettype wire

// ---- verilog/ptc_unit_control.sv ----
// Purpose: control of the time-stamp unit: enable, drain-disable, unit reset, port enables, pin clear
// Assumes: frameBusy and timerBEvent come from logic on ref_clk; polarity bits are static per use
// Notes:   register bus is classic Wishbone, every access answered one cycle after it is seen
// Function
// - writing one to enable turns the unit on; zero changes nothing (code ignores an enable write while draining or before strap capture)
// - reading enable returns the live enabled state
// - disable write clears enable once in-flight frame processing ends; zero ignored
// - no new frame starts while a disable is pending
// - unit reset write restores unit state and registers, clears enable; code keeps event status and event mask
// - after device reset the enable takes the strap value
// - three per-port enables gate each port unit, all set at reset
// - a port unit runs only with its own enable and global enable
// - with clear enable set, a pin edge clears the timer B flag
// - three-bit select, zero at reset, picks one of eight pins
// - active level of the selected pin follows its polarity bit
// - clear is edge detected; pin must stay active over 40 ns (code fires on first synchronised active cycle, CLR_MIN_CYC is 1)
`timescale 1ns/10ps
`default_nettype none
module ptc_unit_control (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // register bus
  input  wire ptc_pkg::ptc_wb_req_type      wbReq,
  output var  ptc_pkg::ptc_wb_rsp_type      wbRsp,
  // strap and pins
  input  wire logic                         enableStrap,
  input  wire logic [ptc_pkg::GPIO_COUNT-1:0] gpioIn,
  input  wire logic [ptc_pkg::GPIO_COUNT-1:0] pinPolarityBits,
  // frame engine
  input  wire logic                         frameBusy,
  output logic                              frameStartAllow,
  output logic                              unitEnabled,
  output var  logic [ptc_pkg::PORT_COUNT-1:0] portStampActive,
  output var  logic                         unitResetPulse,
  // timer interrupt and event interrupt
  input  wire logic                         timerBEvent,
  output var  logic                         timerBFlag,
  output logic                              irq
);
  import ptc_pkg::*;

  function automatic logic regHit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] ofs);
    regHit = (adr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : regHit

  ptc_run_type           runState_r;
  ptc_run_type           runState_nxt;
  ptc_gen_cfg_type       genCfg_r;
  logic                  wbAck_r;
  logic [DATA_W-1:0]     wbDat_r;
  logic [DATA_W-1:0]     readData;
  logic                  reqNew;
  logic                  commit;
  logic                  cmdWr;
  logic                  cfgWr;
  logic                  unitRst;
  logic                  drainDone;
  logic                  stsRead;
  logic [EVT_W-1:0]      evtSts_r;
  logic [EVT_W-1:0]      evtMask_r;
  logic [EVT_W-1:0]      evtSet;
  logic [SYNC_W-1:0]     pinStable;
  logic [2:0]            strapCnt_r;
  logic                  strapDone_r;
  logic                  clrActive;
  logic [1:0]            holdCnt_r;
  logic                  clrFire;
  logic                  gpioClr;

  // bus decode: a request is taken when seen, committed on the edge that shows ack
  assign reqNew  = wbReq.cyc && wbReq.stb && !wbAck_r;
  assign commit  = wbReq.cyc && wbReq.stb && wbAck_r;
  assign cmdWr   = commit && wbReq.we && regHit(wbReq.adr, CMD_CTL_OFS) && wbReq.sel[CMD_LANE];
  assign cfgWr   = commit && wbReq.we && regHit(wbReq.adr, GEN_CFG_OFS);
  assign stsRead = commit && !wbReq.we && regHit(wbReq.adr, EVT_STS_OFS);
  assign unitRst = cmdWr && wbReq.dat[CMD_RESET_BIT];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wbAck_r <= 1'b0;
    end else begin
      wbAck_r <= reqNew;
    end
  end

  always_comb begin
    readData = '0;
    if (regHit(wbReq.adr, CMD_CTL_OFS)) begin
      readData[CMD_ENABLE_BIT] = unitEnabled;
    end else if (regHit(wbReq.adr, GEN_CFG_OFS)) begin
      readData[CFG_PORT_LSB +: PORT_COUNT] = genCfg_r.portEn;
      readData[CFG_CLR_EN_BIT]             = genCfg_r.clrEn;
      readData[CFG_SEL_LSB +: CFG_SEL_W]   = genCfg_r.clrSel;
    end else if (regHit(wbReq.adr, EVT_STS_OFS)) begin
      readData[EVT_W-1:0] = evtSts_r;
    end else if (regHit(wbReq.adr, EVT_MASK_OFS)) begin
      readData[EVT_W-1:0] = evtMask_r;
    end else if (regHit(wbReq.adr, INT_STS_OFS)) begin
      readData[TIMER_B_BIT] = timerBFlag;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wbDat_r <= '0;
    end else if (reqNew) begin
      wbDat_r <= wbReq.we ? '0 : readData;
    end
  end

  assign wbRsp.ack = wbAck_r;
  assign wbRsp.dat = wbDat_r;

  // strap capture once the synchroniser has settled after reset release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strapCnt_r  <= 3'h0;
      strapDone_r <= 1'b0;
    end else if (!strapDone_r) begin
      strapCnt_r <= strapCnt_r + 3'h1;
      if (strapCnt_r == STRAP_SETTLE_CYC) begin
        strapDone_r <= 1'b1;
      end
    end
  end

  // run state: off, on, or draining toward off
  always_comb begin
    runState_nxt = runState_r;
    case (runState_r)
      RUN_OFF: begin
        if (cmdWr && wbReq.dat[CMD_ENABLE_BIT]) begin
          runState_nxt = wbReq.dat[CMD_DISABLE_BIT] ? RUN_DRAIN : RUN_ON;
        end
      end
      RUN_ON: begin
        if (cmdWr && wbReq.dat[CMD_DISABLE_BIT]) begin
          runState_nxt = RUN_DRAIN;
        end
      end
      RUN_DRAIN: begin
        if (!frameBusy) begin
          runState_nxt = RUN_OFF;
        end
      end
      default: runState_nxt = RUN_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      runState_r <= RUN_OFF;
    end else if (unitRst) begin
      runState_r <= RUN_OFF;
    end else if (!strapDone_r) begin
      if (strapCnt_r == STRAP_SETTLE_CYC) begin
        runState_r <= pinStable[STRAP_IDX] ? RUN_ON : RUN_OFF;
      end
    end else begin
      runState_r <= runState_nxt;
    end
  end

  assign unitEnabled     = (runState_r != RUN_OFF);
  assign frameStartAllow = (runState_r == RUN_ON);
  assign drainDone       = (runState_r == RUN_DRAIN) && !frameBusy && !unitRst && strapDone_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      unitResetPulse <= 1'b0;
    end else begin
      unitResetPulse <= unitRst;
    end
  end

  // general configuration; unit reset restores its defaults
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      genCfg_r.portEn <= PORT_EN_RST;
      genCfg_r.clrEn  <= CLR_EN_RST;
      genCfg_r.clrSel <= CLR_SEL_RST;
    end else if (unitRst) begin
      genCfg_r.portEn <= PORT_EN_RST;
      genCfg_r.clrEn  <= CLR_EN_RST;
      genCfg_r.clrSel <= CLR_SEL_RST;
    end else if (cfgWr) begin
      if (wbReq.sel[CFG_PORT_LANE]) begin
        genCfg_r.portEn <= wbReq.dat[CFG_PORT_LSB +: PORT_COUNT];
      end
      if (wbReq.sel[CFG_CLR_LANE]) begin
        genCfg_r.clrEn  <= wbReq.dat[CFG_CLR_EN_BIT];
        genCfg_r.clrSel <= wbReq.dat[CFG_SEL_LSB +: CFG_SEL_W];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      portStampActive <= '0;
    end else begin
      portStampActive <= genCfg_r.portEn & {PORT_COUNT{unitEnabled}};
    end
  end

  // pin clear path
  ptc_pin_sync u_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pinIn     ({enableStrap, gpioIn}),
    .pinStable (pinStable)
  );

  assign clrActive = ~(pinStable[genCfg_r.clrSel] ^ pinPolarityBits[genCfg_r.clrSel]);

  // fires once per activation, on the first active cycle since CLR_MIN_CYC is 1
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      holdCnt_r <= 2'h0;
    end else if (!clrActive) begin
      holdCnt_r <= 2'h0;
    end else if (holdCnt_r < CLR_MIN_CYC) begin
      holdCnt_r <= holdCnt_r + 2'h1;
    end
  end

  assign clrFire = clrActive && (holdCnt_r == CLR_MIN_CYC - 2'h1);
  assign gpioClr = clrFire && genCfg_r.clrEn;

  // timer B flag: a new event wins over a pin or register clear in the same cycle; unit reset wins over the event
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timerBFlag <= 1'b0;
    end else if (unitRst) begin
      timerBFlag <= 1'b0;
    end else if (timerBEvent) begin
      timerBFlag <= 1'b1;
    end else if (gpioClr) begin
      timerBFlag <= 1'b0;
    end else if (commit && wbReq.we && regHit(wbReq.adr, INT_STS_OFS)
                 && wbReq.sel[EVT_LANE] && wbReq.dat[TIMER_B_BIT]) begin
      timerBFlag <= 1'b0;
    end
  end

  // event status: read clears only the bits that were returned
  always_comb begin
    evtSet                     = '0;
    evtSet[EVT_DRAIN_DONE_BIT] = drainDone;
    evtSet[EVT_GPIO_CLEAR_BIT] = gpioClr;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      evtSts_r <= '0;
    end else begin
      evtSts_r <= (evtSts_r & ~(stsRead ? wbDat_r[EVT_W-1:0] : {EVT_W{1'b0}})) | evtSet;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      evtMask_r <= EVT_MASK_RST;
    end else if (commit && wbReq.we && regHit(wbReq.adr, EVT_MASK_OFS) && wbReq.sel[EVT_LANE]) begin
      evtMask_r <= wbReq.dat[EVT_W-1:0];
    end
  end

  assign irq = |(evtSts_r & evtMask_r);

  chk_enable_write_on: assert property (@(posedge ref_clk) disable iff (reset)
    (cmdWr && wbReq.dat[CMD_ENABLE_BIT] && !wbReq.dat[CMD_RESET_BIT] && strapDone_r) |=> unitEnabled)
    else $error("enable write did not turn the unit on");

  chk_zero_write_noop: assert property (@(posedge ref_clk) disable iff (reset)
    (cmdWr && (wbReq.dat[2:0] == 3'h0) && (runState_r != RUN_DRAIN) && strapDone_r)
    |=> (unitEnabled == $past(unitEnabled)))
    else $error("zero command write changed the enable");

  chk_enable_readback: assert property (@(posedge ref_clk) disable iff (reset)
    (reqNew && !wbReq.we && regHit(wbReq.adr, CMD_CTL_OFS))
    |=> (wbRsp.ack && (wbRsp.dat[CMD_ENABLE_BIT] == $past(unitEnabled))))
    else $error("enable readback wrong or late");

  chk_drain_holds: assert property (@(posedge ref_clk) disable iff (reset)
    ((runState_r == RUN_DRAIN) && frameBusy && !unitRst) |=> unitEnabled)
    else $error("enable cleared while frames still in flight");

  chk_drain_ends: assert property (@(posedge ref_clk) disable iff (reset)
    ((runState_r == RUN_DRAIN) && !frameBusy && strapDone_r)
    |=> (!unitEnabled && evtSts_r[EVT_DRAIN_DONE_BIT]))
    else $error("drain did not finish one cycle after frames ended");

  chk_no_new_frame: assert property (@(posedge ref_clk) disable iff (reset)
    (((runState_r == RUN_DRAIN) || !unitEnabled) |-> !frameStartAllow)
    and ((cmdWr && wbReq.dat[CMD_DISABLE_BIT] && strapDone_r) |=> !frameStartAllow))
    else $error("frame start allowed while disabling or off");

  chk_unit_reset: assert property (@(posedge ref_clk) disable iff (reset)
    unitRst |=> (unitResetPulse && !unitEnabled && (genCfg_r.portEn == PORT_EN_RST)
                 && !genCfg_r.clrEn && !timerBFlag))
    else $error("unit reset did not restore state");

  chk_strap_load: assert property (@(posedge ref_clk) disable iff (reset)
    (!strapDone_r && (strapCnt_r == STRAP_SETTLE_CYC) && !unitRst)
    |=> (unitEnabled == $past(pinStable[STRAP_IDX])))
    else $error("enable did not follow the strap");

  chk_port_gate: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> (portStampActive == ($past(genCfg_r.portEn) & {PORT_COUNT{$past(unitEnabled)}})))
    else $error("port activity not gated by both enables");

  chk_pin_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (clrFire && genCfg_r.clrEn && !timerBEvent) ##1 !timerBEvent |-> !timerBFlag)
    else $error("pin edge did not clear timer B flag");

  chk_clear_once: assert property (@(posedge ref_clk) disable iff (reset)
    clrFire |=> !clrFire)
    else $error("pin clear fired twice for one activation");

endmodule : ptc_unit_control
`default_nettype wire

// ---- verif/ptc_host_model.sv ----
// Purpose: host software model driving the register bus as a classic Wishbone master
// Assumes: slave answers within a few cycles; one word per access
// Notes:   hostHang rises when an answer or a wait runs out of its bound
`timescale 1ns/10ps
`default_nettype none
module ptc_host_model (
  // clock
  input  wire logic                    ref_clk,
  // register bus
  output var  ptc_pkg::ptc_wb_req_type wbReq,
  input  wire ptc_pkg::ptc_wb_rsp_type wbRsp,
  // bench status
  output var  logic                    hostHang
);
  import ptc_pkg::*;

  initial begin
    wbReq    = '0;
    hostHang = 1'b0;
  end

  // one access: request held until the edge that samples ack, then released
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
    int n;
    @(posedge ref_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 16);
    if (wbRsp.ack !== 1'b1) hostHang <= 1'b1;
    rdat = wbRsp.dat;
    wbReq <= '0;
  endtask : xfer

  // unit reset and port-enable changes only once enable reads clear
  task automatic wait_off();
    logic [31:0] d;
    int          n;
    d = 32'h4;
    for (n = 0; n < 32 && d[CMD_ENABLE_BIT] !== 1'b0; n++) begin
      xfer(1'b0, CMD_CTL_OFS, 32'h0, d);
    end
    if (d[CMD_ENABLE_BIT] !== 1'b0) hostHang <= 1'b1;
  endtask : wait_off
endmodule : ptc_host_model
`default_nettype wire

// ---- verif/test_ptp_unit_control.sv ----
// Purpose: self-checking bench for the time-stamp unit control block
// Assumes: host model drives the register bus; frame engine and pins driven here
// Notes:   polarity 8'h55, idle pins 8'haa so every pin rests inactive
`timescale 1ns/10ps
`default_nettype none
module test_ptp_unit_control;
  import ptc_pkg::*;

  logic            ref_clk;
  logic            reset;
  ptc_wb_req_type  wbReq;
  ptc_wb_rsp_type  wbRsp;
  logic            enableStrap;
  logic [7:0]      gpioIn;
  logic [7:0]      pinPolarityBits;
  logic            frameBusy;
  logic            frameStartAllow;
  logic            unitEnabled;
  logic [2:0]      portStampActive;
  logic            unitResetPulse;
  logic            timerBEvent;
  logic            timerBFlag;
  logic            irq;
  logic            hostHang;
  int              mismatches;
  int              total_checks;

  ptc_unit_control dut (
    .ref_clk(ref_clk), .reset(reset), .wbReq(wbReq), .wbRsp(wbRsp), .enableStrap(enableStrap),
    .gpioIn(gpioIn), .pinPolarityBits(pinPolarityBits), .frameBusy(frameBusy),
    .frameStartAllow(frameStartAllow), .unitEnabled(unitEnabled), .portStampActive(portStampActive),
    .unitResetPulse(unitResetPulse), .timerBEvent(timerBEvent), .timerBFlag(timerBFlag), .irq(irq)
  );

  ptc_host_model host (
    .ref_clk(ref_clk), .wbReq(wbReq), .wbRsp(wbRsp), .hostHang(hostHang)
  );

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (hostHang === 1'b1) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    host.xfer(1'b1, adr, dat, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    host.xfer(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    reset       <= 1'b1;
    enableStrap <= strap;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : do_reset

  task automatic pulse_timer_b();
    @(posedge ref_clk);
    timerBEvent <= 1'b1;
    @(posedge ref_clk);
    timerBEvent <= 1'b0;
    settle();
  endtask : pulse_timer_b

  // pins stay inputs driven only by the bench; 75 ns active pulse
  task automatic pin_pulse(input int p, input logic exp);
    @(posedge ref_clk);
    gpioIn <= 8'haa ^ (8'h01 << p);
    repeat (3) @(posedge ref_clk);
    gpioIn <= 8'haa;
    for (int n = 0; n < 12; n++) begin
      @(posedge ref_clk);
      if (exp == 1'b0 && timerBFlag === 1'b0) break;
    end
    #1;
    check(32'(timerBFlag), 32'(exp));
  endtask : pin_pulse

  task automatic t_strap();
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      check(32'(unitEnabled), 32'(s[0]));
      rdchk(CMD_CTL_OFS, {29'h0, s[0], 2'h0});
      rdchk(GEN_CFG_OFS, 32'h0007_0000);
      rdchk(EVT_MASK_OFS, 32'h0);
      rdchk(32'h0000_01fc, 32'h0);
      check(32'(portStampActive), 32'({3{s[0]}}));
    end
  endtask : t_strap

  task automatic t_drain();
    wr(EVT_MASK_OFS, 32'h1);
    @(posedge ref_clk);
    frameBusy <= 1'b1;
    wr(CMD_CTL_OFS, 32'h0);
    settle();
    check(32'(unitEnabled), 32'h1);
    wr(CMD_CTL_OFS, 32'h2);
    settle();
    check(32'(frameStartAllow), 32'h0);
    rdchk(CMD_CTL_OFS, 32'h4);
    wr(CMD_CTL_OFS, 32'h4);
    settle();
    check(32'(frameStartAllow), 32'h0);
    check(32'(irq), 32'h0);
    @(posedge ref_clk);
    frameBusy <= 1'b0;
    settle();
    check(32'(unitEnabled), 32'h0);
    check(32'(irq), 32'h1);
    rdchk(EVT_STS_OFS, 32'h1);
    settle();
    check(32'(irq), 32'h0);
    rdchk(EVT_STS_OFS, 32'h0);
  endtask : t_drain

  task automatic t_enable();
    host.wait_off();
    wr(GEN_CFG_OFS, 32'h0005_0000);
    rdchk(GEN_CFG_OFS, 32'h0005_0000);
    settle();
    check(32'(portStampActive), 32'h0);
    wr(CMD_CTL_OFS, 32'h4);
    settle();
    check(32'(unitEnabled), 32'h1);
    check(32'(frameStartAllow), 32'h1);
    check(32'(portStampActive), 32'h5);
  endtask : t_enable

  task automatic t_unit_reset();
    int n;
    pulse_timer_b();
    check(32'(timerBFlag), 32'h1);
    wr(CMD_CTL_OFS, 32'h2);
    host.wait_off();
    // the drain above raised the drain-finished event; clear it so later status reads start clean
    settle();
    check(32'(irq), 32'h1);
    rdchk(EVT_STS_OFS, 32'h1);
    wr(GEN_CFG_OFS, 32'h0000_d000);
    wr(CMD_CTL_OFS, 32'h1);
    n = 0;
    repeat (4) begin
      #1;
      if (unitResetPulse === 1'b1) n++;
      @(posedge ref_clk);
    end
    #1;
    check(32'(n), 32'h1);
    check(32'(timerBFlag), 32'h0);
    rdchk(GEN_CFG_OFS, 32'h0007_0000);
    rdchk(CMD_CTL_OFS, 32'h0);
  endtask : t_unit_reset

  task automatic t_pin_clear();
    pulse_timer_b();
    pin_pulse(0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(GEN_CFG_OFS, 32'h0007_8000 | (i << 12));
      pin_pulse((i + 1) % 8, 1'b1);
      pin_pulse(i, 1'b0);
      rdchk(EVT_STS_OFS, 32'h2);
      pulse_timer_b();
    end
    wr(INT_STS_OFS, 32'h2);
    settle();
    check(32'(timerBFlag), 32'h0);
  endtask : t_pin_clear

  initial begin
    ref_clk         = 1'b0;
    reset           = 1'b1;
    enableStrap     = 1'b0;
    gpioIn          = 8'haa;
    pinPolarityBits = 8'h55;
    frameBusy       = 1'b0;
    timerBEvent     = 1'b0;
    mismatches      = 0;
    total_checks    = 0;
    t_strap();
    t_drain();
    t_enable();
    t_unit_reset();
    t_pin_clear();
    end_sim();
  end
endmodule : test_ptp_unit_control
`default_nettype wire
